//--- design/sacs_sequencer.sv
// Purpose: Acquisition and successive-approximation conversion sequencer
// Assumes: Host pins synchronous to CLK; comparator settles within a tick
// Notes:   Converter clock is one-cycle enable on the selected falling edge
`default_nettype none

module sacs_sequencer (
    // System
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // Host parallel port
    input  wire logic       CS_N,
    input  wire logic       WR_N,
    input  wire logic       RD_N,
    input  wire logic       UPPER_BYTE_SELECT,
    input  wire logic [7:0] DATA_IN,
    output logic      [7:0] DATA_OUT,
    output logic            DATA_OE,
    output logic            DONE_N,
    // External converter clock pin
    input  wire logic       EXT_CLK,
    // Analog front end control
    input  wire logic       COMP_IN,
    output logic      [9:0] DAC_CODE,
    output logic            TRACK,
    output logic            HOLD_TO_NEG,
    output logic            NEG_TO_RETURN,
    output logic      [2:0] MUX_POS_SEL,
    output logic      [2:0] MUX_NEG_SEL,
    output logic            POLARITY_SELECT,
    output logic            CONV_BUSY
);

    sacs_pkg::sacs_state_type state_reg;
    sacs_pkg::sacs_ctrl_type  ctrl_reg;
    logic                     clk_ext_reg;
    logic [3:0]               tick_cnt_reg;
    logic [3:0]               div_cnt_reg;
    logic [9:0]               sar_reg;
    logic [9:0]               result_reg;
    logic                     done_n_reg;
    logic [7:0]               data_out_reg;

    logic wr_rise;
    logic rd_fall;
    logic ext_fall;
    logic div_tick;
    logic tick;
    logic host_write;
    logic read_start;
    logic ext_hold;
    logic int_hold;
    logic conv_last;
    logic sar_active;
    logic [9:0] sar_bit;
    logic [9:0] sar_kept;
    sacs_pkg::sacs_ctrl_type  ctrl_new;

    // Assertions sample on CLK and rest during reset
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // Edge detection of host strobes and the external clock pin
    sacs_edge #(.IDLE_LEVEL(1'b1)) u_wr_edge (
        .clk      (CLK),
        .rst      (SYS_RST),
        .level_in (WR_N),
        .rise     (wr_rise),
        .fall     ()
    );
    sacs_edge #(.IDLE_LEVEL(1'b1)) u_rd_edge (
        .clk      (CLK),
        .rst      (SYS_RST),
        .level_in (RD_N),
        .rise     (),
        .fall     (rd_fall)
    );
    sacs_edge #(.IDLE_LEVEL(1'b0)) u_ck_edge (
        .clk      (CLK),
        .rst      (SYS_RST),
        .level_in (EXT_CLK),
        .rise     (),
        .fall     (ext_fall)
    );

    // Strobe decode and tick source selection
    assign host_write = wr_rise & ~CS_N;
    assign read_start = rd_fall & ~CS_N;
    assign div_tick   = (div_cnt_reg == sacs_pkg::DIV_CNT_LAST);
    assign tick       = clk_ext_reg ? ext_fall : div_tick;
    assign ctrl_new   = sacs_pkg::sacs_ctrl_type'(DATA_IN);

    chk_tick_src: assert property (clk_ext_reg |-> tick == ext_fall)
        else $error("tick not from external clock");

    // Acquisition and conversion end conditions
    assign ext_hold = (state_reg == sacs_pkg::ST_ACQ)
                    & ctrl_reg.sample_timing_select & host_write;
    assign int_hold = (state_reg == sacs_pkg::ST_ACQ)
                    & ~ctrl_reg.sample_timing_select & tick
                    & (tick_cnt_reg == sacs_pkg::ACQ_CNT_LAST);
    assign conv_last = (state_reg == sacs_pkg::ST_CONV) & tick
                     & (tick_cnt_reg == sacs_pkg::TICK_CNT_LAST);

    // Successive approximation trial bit and kept value
    assign sar_active = (state_reg == sacs_pkg::ST_CONV)
                      & (tick_cnt_reg <= sacs_pkg::SAR_CNT_LAST);
    assign sar_bit    = sacs_pkg::SAR_MSB >> tick_cnt_reg;
    assign sar_kept   = COMP_IN ? sar_reg : (sar_reg & ~sar_bit);

    // Internal oscillator divider
    always_ff @(posedge CLK) begin
        if (SYS_RST || div_tick) begin
            div_cnt_reg <= 4'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
        end
    end

    // Sequencer state, control byte and clock mode
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg    <= sacs_pkg::ST_IDLE;
            ctrl_reg     <= sacs_pkg::sacs_ctrl_type'(sacs_pkg::CTRL_RESET);
            clk_ext_reg  <= sacs_pkg::CLK_EXT_RESET;
            tick_cnt_reg <= 4'h0;
        end else if (host_write) begin
            ctrl_reg     <= ctrl_new;
            tick_cnt_reg <= 4'h0;
            if (ctrl_new.pd1) begin
                clk_ext_reg <= ctrl_new.pd0;          // Power-down keeps mode
            end
            if (ext_hold) begin
                state_reg <= sacs_pkg::ST_CONV;
            end else begin
                state_reg <= sacs_pkg::ST_ACQ;
            end
        end else begin
            case (state_reg)
                sacs_pkg::ST_ACQ: begin
                    if (int_hold) begin
                        state_reg    <= sacs_pkg::ST_CONV;
                        tick_cnt_reg <= 4'h0;
                    end else if (tick && !ctrl_reg.sample_timing_select) begin
                        tick_cnt_reg <= tick_cnt_reg + 4'h1;
                    end
                end
                sacs_pkg::ST_CONV: begin
                    if (conv_last) begin
                        state_reg    <= sacs_pkg::ST_IDLE;
                        tick_cnt_reg <= 4'h0;
                    end else if (tick) begin
                        tick_cnt_reg <= tick_cnt_reg + 4'h1;
                    end
                end
                default: begin
                    state_reg <= sacs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    chk_track_start: assert property (host_write && !ext_hold |=> TRACK)
        else $error("write did not start tracking");
    chk_ext_hold: assert property (ext_hold |=> HOLD_TO_NEG && !TRACK)
        else $error("host timed hold missed");
    chk_int_hold: assert property (int_hold && !host_write |=> CONV_BUSY)
        else $error("internal hold missed on fourth tick");
    chk_conv_len: assert property (conv_last && !host_write
        |=> !CONV_BUSY && !DONE_N)
        else $error("conversion length wrong");
    chk_conv_count: assert property (CONV_BUSY
        |-> tick_cnt_reg <= sacs_pkg::TICK_CNT_LAST)
        else $error("conversion tick count overrun");
    chk_abort_conv: assert property (CONV_BUSY && host_write && !ext_hold
        |=> TRACK && DONE_N)
        else $error("write did not abort conversion");

    // Approximation register and held result
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sar_reg    <= sacs_pkg::SAR_MSB;
            result_reg <= sacs_pkg::RESULT_RESET;
        end else if (state_reg != sacs_pkg::ST_CONV) begin
            sar_reg <= sacs_pkg::SAR_MSB;
        end else if (tick && sar_active) begin
            sar_reg <= sar_kept | (sar_bit >> 1);
        end else if (conv_last) begin
            result_reg <= sar_reg;
        end
    end

    chk_result_hold: assert property (!conv_last |=> $stable(result_reg))
        else $error("result changed outside completion");

    // Done flag: completion wins over a read in the same cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            done_n_reg <= 1'b1;
        end else if (conv_last && !host_write) begin
            done_n_reg <= 1'b0;
        end else if (read_start || host_write) begin
            done_n_reg <= 1'b1;
        end
    end

    // Byte lane of the result
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            data_out_reg <= 8'h00;
        end else if (UPPER_BYTE_SELECT) begin
            data_out_reg <= {6'h00, result_reg[9:8]};
        end else begin
            data_out_reg <= result_reg[7:0];
        end
    end

    chk_upper_lane: assert property (UPPER_BYTE_SELECT
        |=> DATA_OUT == {6'h00, $past(result_reg[9:8])})
        else $error("upper lane wrong");

    // Outputs
    assign DATA_OUT        = data_out_reg;
    assign DATA_OE         = ~CS_N & ~RD_N;
    assign DONE_N          = done_n_reg;
    assign DAC_CODE        = sar_reg;
    assign TRACK           = (state_reg == sacs_pkg::ST_ACQ);
    assign HOLD_TO_NEG     = (state_reg == sacs_pkg::ST_CONV);
    assign CONV_BUSY       = (state_reg == sacs_pkg::ST_CONV);
    assign POLARITY_SELECT = ctrl_reg.polarity_select;
    assign NEG_TO_RETURN   = ctrl_reg.input_pairing_select;
    assign MUX_POS_SEL     = ctrl_reg.chan;
    assign MUX_NEG_SEL     = ctrl_reg.input_pairing_select ? 3'h0
                           : {ctrl_reg.chan[2:1], ~ctrl_reg.chan[0]};

    chk_single_end: assert property (ctrl_reg.input_pairing_select
        |-> NEG_TO_RETURN && MUX_POS_SEL == ctrl_reg.chan)
        else $error("single-ended routing wrong");

endmodule

`default_nettype wire

//--- design/sacs_pkg.sv
// Purpose: Shared constants and types for the converter sequencer
// Assumes: 10 MHz system clock, control byte layout D7..D0
// Notes:   Internal oscillator is a divided enable of the system clock
`default_nettype none

package sacs_pkg;

    // System clock and timing
    localparam int CLK_PERIOD_NS    = 100;
    localparam int INT_ACQ_TIME_NS  = 1000;   // Internal hold point, approx
    localparam int ACQ_HOLD_TICKS   = 4;      // Falling edges to hold
    localparam int INT_TICK_CYCLES  =
        INT_ACQ_TIME_NS / ACQ_HOLD_TICKS / CLK_PERIOD_NS;
    localparam int CONV_TICKS       = 13;     // Clock cycles per conversion
    localparam int RESULT_BITS      = 10;

    localparam logic [3:0] TICK_CNT_LAST   = 4'(CONV_TICKS - 1);
    localparam logic [3:0] ACQ_CNT_LAST    = 4'(ACQ_HOLD_TICKS - 1);
    localparam logic [3:0] SAR_CNT_LAST    = 4'(RESULT_BITS - 1);
    localparam logic [3:0] DIV_CNT_LAST    = 4'(INT_TICK_CYCLES - 1);

    // Control byte field positions
    localparam int CB_PD1_POS    = 7;
    localparam int CB_PD0_POS    = 6;
    localparam int CB_ACQ_POS    = 5;
    localparam int CB_PAIR_POS   = 4;
    localparam int CB_POL_POS    = 3;

    // Reset values
    localparam logic [7:0] CTRL_RESET      = 8'hD8;   // External clock mode
    localparam logic       CLK_EXT_RESET   = 1'b1;
    localparam logic [9:0] RESULT_RESET    = 10'h000;
    localparam logic [9:0] SAR_MSB         = 10'h200;

    // Decoded control byte
    typedef struct packed {
        logic       pd1;
        logic       pd0;
        logic       sample_timing_select;  // 1: host timed acquisition
        logic       input_pairing_select;  // 1: single-ended
        logic       polarity_select;       // 1: unipolar
        logic [2:0] chan;
    } sacs_ctrl_type;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ  = 2'b01,
        ST_CONV = 2'b10
    } sacs_state_type;

endpackage

`default_nettype wire

//--- design/sacs_edge.sv
// Purpose: Registered edge detector for a synchronous input
// Assumes: Input already synchronous to the clock
// Notes:   Reset level chosen by parameter to avoid a false edge
`default_nettype none

module sacs_edge #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level in, pulses out
    input  wire logic level_in,
    output logic      rise,
    output logic      fall
);

    logic last_reg;

    // Previous sample
    always_ff @(posedge clk) begin
        if (rst) begin
            last_reg <= IDLE_LEVEL;
        end else begin
            last_reg <= level_in;
        end
    end

    // Edge pulses
    assign rise = level_in & ~last_reg;
    assign fall = ~level_in & last_reg;

endmodule

`default_nettype wire

//--- testbench/sacs_comp_model.sv
// Purpose: Comparator model facing the sequencer's trial code
// Assumes: Analog level given as a 10-bit code by the bench
// Notes:   Output toggles outside conversion so it is never trusted
`default_nettype none

module sacs_comp_model (
    // Clock
    input  wire logic       CLK,
    // Converter side
    input  wire logic       HOLD_TO_NEG,
    input  wire logic [9:0] DAC_CODE,
    input  wire logic [9:0] LEVEL,
    output logic            COMP_IN
);
    timeunit 1ns;
    timeprecision 1ns;

    logic junk_reg = 1'b0;

    // Changing pattern while not converting
    always @(posedge CLK) junk_reg <= ~junk_reg;

    // Keep trial bit while the trial code is not above the level
    assign COMP_IN = HOLD_TO_NEG ? (DAC_CODE <= LEVEL) : junk_reg;
endmodule

`default_nettype wire

//--- testbench/sar_adc_conversion_sequencer_tb_top.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Inputs driven at falling CLK edges, 100 ns clock
// Notes:   Cycle counts are measured at falling edges
`default_nettype none

module sar_adc_conversion_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0, sys_rst = 1'b1, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
    logic ubs = 1'b0, ext_clk = 1'b0, comp_in, data_oe, done_n, track;
    logic hold_to_neg, neg_to_return, polarity_select, conv_busy;
    logic [7:0] data_in = 8'h00, data_out, rd_byte;
    logic [9:0] dac_code, level = 10'h000;
    logic [2:0] mux_pos_sel, mux_neg_sel;
    int n_mismatch = 0, compares = 0, n;
    logic [7:0] cfg [2] = '{8'h9B, 8'h85};
    logic [9:0] lvl [2] = '{10'h2A5, 10'h15A};

    sacs_sequencer dut (.CLK(clk), .SYS_RST(sys_rst), .CS_N(cs_n),
        .WR_N(wr_n), .RD_N(rd_n), .UPPER_BYTE_SELECT(ubs),
        .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe),
        .DONE_N(done_n), .EXT_CLK(ext_clk), .COMP_IN(comp_in),
        .DAC_CODE(dac_code), .TRACK(track), .HOLD_TO_NEG(hold_to_neg),
        .NEG_TO_RETURN(neg_to_return), .MUX_POS_SEL(mux_pos_sel),
        .MUX_NEG_SEL(mux_neg_sel), .POLARITY_SELECT(polarity_select),
        .CONV_BUSY(conv_busy));
    sacs_comp_model comp (.CLK(clk), .HOLD_TO_NEG(hold_to_neg),
        .DAC_CODE(dac_code), .LEVEL(level), .COMP_IN(comp_in));

    // System clock and external converter clock, six cycles a period
    initial begin
        forever #50 clk = ~clk;
    end
    always begin
        repeat (3) @(negedge clk);
        ext_clk = ~ext_clk;
    end

    // Result and range comparisons
    task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rng(string what, int lo, int hi, int got);
        compares++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Selected status level
    function automatic logic sel(int w);
        return (w == 0) ? track : (w == 1) ? hold_to_neg : done_n;
    endfunction
    // Wait up to lim cycles for a level
    task automatic wait_lvl(int w, logic v, int lim);
        for (int i = 0; i < lim && sel(w) !== v; i++) @(negedge clk);
    endtask
    // Cycles a level stays high
    task automatic len(int w, output int k);
        k = 0;
        while (sel(w) === 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
    endtask

    // Host write pulse and read cycle
    task automatic wr(logic [7:0] b, logic cs);
        @(negedge clk);
        cs_n = cs;
        wr_n = 1'b0;
        data_in = b;
        @(negedge clk);
        wr_n = 1'b1;
        @(negedge clk);
        cs_n = 1'b1;
    endtask
    task automatic rd(logic up, output logic [7:0] b);
        @(negedge clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        ubs = up;
        repeat (2) @(negedge clk);
        chk("output enable", 10'h001, {9'h000, data_oe});
        b = data_out;
        rd_n = 1'b1;
        cs_n = 1'b1;
    endtask
    task automatic rd_chk(logic [9:0] exp);
        rd(1'b0, rd_byte);
        chk("low byte", {2'b00, exp[7:0]}, {2'b00, rd_byte});
        rd(1'b1, rd_byte);
        chk("high bits", {8'h00, exp[9:8]}, {2'b00, rd_byte});
    endtask

    task automatic conclude();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well above the expected few hundred cycles
    initial begin
        #2000000;
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        chk("reset done", 10'h001, {9'h000, done_n});
        chk("reset track", 10'h000, {9'h000, track});
        $display("test reset done");
        // Internal clock and acquisition, single-ended then paired
        for (int i = 0; i < 2; i++) begin
            level = lvl[i];
            wr(cfg[i], 1'b0);
            wait_lvl(0, 1'b1, 3);
            chk("track", 10'h001, {9'h000, track});
            len(0, n);
            chk_rng("acq cycles", 7, 10, n);
            chk("pos sel", {7'h00, cfg[i][2:0]}, {7'h00, mux_pos_sel});
            chk("neg sel", (i == 0) ? 10'h000 : 10'h004,
                {7'h00, mux_neg_sel});
            chk("return", {9'h000, cfg[i][4]}, {9'h000, neg_to_return});
            chk("polarity", {9'h000, cfg[i][3]},
                {9'h000, polarity_select});
            chk("busy", 10'h001, {9'h000, conv_busy});
            chk("first trial", 10'h200, dac_code);
            len(1, n);
            chk_rng("conv cycles", 25, 26, n);
            chk("done", 10'h000, {9'h000, done_n});
            rd_chk(lvl[i]);
            chk("done cleared", 10'h001, {9'h000, done_n});
            $display("test internal %0d done", i);
        end
        // Write with chip select high is ignored
        wr(8'h9B, 1'b1);
        repeat (3) @(negedge clk);
        chk("no track", 10'h000, {9'h000, track});
        // Abort in mid conversion keeps the old result
        level = 10'h0F0;
        wr(8'h9B, 1'b0);
        wait_lvl(1, 1'b1, 20);
        repeat (5) @(negedge clk);
        wr(8'h9B, 1'b0);
        chk("abort track", 10'h001, {9'h000, track});
        chk("abort hold", 10'h000, {9'h000, hold_to_neg});
        chk("abort done", 10'h001, {9'h000, done_n});
        rd_chk(lvl[1]);
        repeat (20) @(negedge clk);
        chk("aborted end", 10'h001, {9'h000, done_n});
        wait_lvl(2, 1'b0, 60);
        rd_chk(10'h0F0);
        $display("test abort done");
        // External clock, host timed acquisition
        level = 10'h333;
        wr(8'hFA, 1'b0);
        repeat (20) @(negedge clk);
        chk("ext track", 10'h001, {9'h000, track});
        wr(8'hDA, 1'b0);
        wait_lvl(1, 1'b1, 3);
        chk("ext hold", 10'h000, {9'h000, track});
        len(1, n);
        chk_rng("ext conv", 72, 78, n);
        rd_chk(10'h333);
        $display("test external done");
        // Power-down byte keeps external clock, internal acquisition
        level = 10'h0C7;
        wr(8'h1B, 1'b0);
        len(0, n);
        chk_rng("kept acq", 19, 24, n);
        len(1, n);
        chk_rng("kept conv", 78, 78, n);
        chk("kept done", 10'h000, {9'h000, done_n});
        rd_chk(10'h0C7);
        $display("test clock kept done");
        conclude();
    end
endmodule

`default_nettype wire
